// ### core/hip_port.sv
// hip_port: host parallel port with indirect 8-bit register access, packet data path and irq.
// assumes host strobes are asynchronous to clk_sys and each strobe low/high phase lasts
// at least three clk_sys periods; user logic supplies packet data and register read data.
// select and data must be steady three clk_sys periods before the strobe falls.
`timescale 1ns/10ps
// Function
// - Command 000 moves sixteen-bit packet data on read or write.
// - Command 001 moves eight-bit internal register data on read or write.
// - Write with command 010 loads address register low byte.
// - Write with command 011 loads address register high byte.
// - Read begins on falling edge of read strobe.
// - Write begins on falling edge of write strobe.
// - Interrupt raised on management, eeprom, receive or transmit-done events.
// - Four cause bits readable at internal address 2000H.
// - Write to 1806H clears management done interrupt.
// - Write to 1C04H clears eeprom done interrupt.
// - Write to 6403H clears packet received interrupt.
// - Write to 6411H clears packet transmitted interrupt.
module hip_port
   import hip_pkg::*;
#(
   parameter int DATA_W = 16
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic [2:0] host_cmd_select,
   input wire logic [DATA_W-1:0] host_data_bus_in,
   output logic [DATA_W-1:0] host_data_bus_out,
   output logic host_data_bus_oe,
   input wire logic host_chip_sel_n,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   output logic host_irq,
   input wire logic [HIP_NUM_IRQ-1:0] irq_event,
   output logic pkt_rd_req,
   input wire logic [DATA_W-1:0] pkt_rd_data,
   output logic pkt_wr_req,
   output logic [DATA_W-1:0] pkt_wr_data,
   output logic reg_rd_req,
   output logic reg_wr_req,
   output logic [15:0] reg_addr,
   output logic [7:0] reg_wr_data,
   input wire logic [7:0] reg_rd_data
);

   // all state in one record; nxt is its combinational copy
   typedef struct packed {
      logic [HIP_SYNC_DEPTH-1:0] rd_sync;
      logic [HIP_SYNC_DEPTH-1:0] wr_sync;
      logic [HIP_SYNC_DEPTH-1:0] cs_sync;
      logic [HIP_SYNC_DEPTH-1:0][2:0] cmd_sync;
      logic [HIP_SYNC_DEPTH-1:0][DATA_W-1:0] din_sync;
      logic [2:0] cmd_level;
      logic [DATA_W-1:0] din_level;
      logic rd_level;
      logic wr_level;
      logic rd_active;
      logic [2:0] rd_cmd;
      logic [15:0] addr;
      logic [HIP_NUM_IRQ-1:0] cause;
      logic [DATA_W-1:0] dout;
      logic pkt_rd;
      logic pkt_wr;
      logic [DATA_W-1:0] wdata;
      logic reg_rd;
      logic reg_wr;
      logic [7:0] reg_wd;
      logic rd_load;
   } hip_state_t;

   hip_state_t cur;
   hip_state_t nxt;

   // true when a write to the given internal address is under way
   function automatic logic hip_clr_hit(input logic [15:0] a, input logic [15:0] target,
                                        input logic wr_ok);
      hip_clr_hit = wr_ok && (a == target);
   endfunction : hip_clr_hit

   // stages two and three agree, so the filtered level may follow them
   function automatic logic hip_agree(input logic [HIP_SYNC_DEPTH-1:0] s);
      hip_agree = (s[1] == s[2]);
   endfunction : hip_agree

   // one-cycle fall: filtered level still high while stages two and three read low
   function automatic logic hip_fall(input logic level, input logic [HIP_SYNC_DEPTH-1:0] s,
                                     input logic sel_ok);
      hip_fall = level && !s[1] && !s[2] && sel_ok;
   endfunction : hip_fall

   logic rd_fall;
   logic wr_fall;
   logic cs_ok;
   logic wr_reg_ok;
   logic [HIP_NUM_IRQ-1:0] clr;

   // a strobe edge counts only once stages two and three agree, so glitches are filtered
   always_comb begin
      cs_ok = !cur.cs_sync[1] && !cur.cs_sync[2];
      rd_fall = hip_fall(cur.rd_level, cur.rd_sync, cs_ok);
      wr_fall = hip_fall(cur.wr_level, cur.wr_sync, cs_ok);
      wr_reg_ok = wr_fall && (cur.cmd_level == HIP_CMD_REG);
      // clear decodes; register writes to any other address leave the causes alone
      clr = '0;
      clr[HIP_IRQ_MGMT] = hip_clr_hit(cur.addr, HIP_ADR_MGMT_CLR, wr_reg_ok);
      clr[HIP_IRQ_EE] = hip_clr_hit(cur.addr, HIP_ADR_EE_CLR, wr_reg_ok);
      clr[HIP_IRQ_RX] = hip_clr_hit(cur.addr, HIP_ADR_RX_CLR, wr_reg_ok);
      clr[HIP_IRQ_TX] = hip_clr_hit(cur.addr, HIP_ADR_TX_CLR, wr_reg_ok);
   end

   // next-state logic; select and data pass three-stage chains like the strobes, since all are pins
   always_comb begin
      nxt = cur;
      nxt.rd_sync = {cur.rd_sync[HIP_SYNC_DEPTH-2:0], read_strobe_n};
      nxt.wr_sync = {cur.wr_sync[HIP_SYNC_DEPTH-2:0], write_strobe_n};
      nxt.cs_sync = {cur.cs_sync[HIP_SYNC_DEPTH-2:0], host_chip_sel_n};
      nxt.cmd_sync = {cur.cmd_sync[HIP_SYNC_DEPTH-2:0], host_cmd_select};
      nxt.din_sync = {cur.din_sync[HIP_SYNC_DEPTH-2:0], host_data_bus_in};
      // a bus word counts once stages two and three agree; a host that changes it
      // within three clk_sys periods of the strobe edge is not supported
      if (cur.cmd_sync[1] == cur.cmd_sync[2]) begin
         nxt.cmd_level = cur.cmd_sync[2];
      end
      if (cur.din_sync[1] == cur.din_sync[2]) begin
         nxt.din_level = cur.din_sync[2];
      end
      if (hip_agree(cur.rd_sync)) begin
         nxt.rd_level = cur.rd_sync[2];
      end
      if (hip_agree(cur.wr_sync)) begin
         nxt.wr_level = cur.wr_sync[2];
      end
      // request pulses last one cycle; the core takes them on the next edge
      nxt.pkt_rd = 1'h0;
      nxt.pkt_wr = 1'h0;
      nxt.reg_rd = 1'h0;
      nxt.reg_wr = 1'h0;
      nxt.rd_load = 1'h0;
      // set wins over clear so an event landing on the clear write is kept
      // there is no mask: any set cause holds host_irq high
      nxt.cause = (cur.cause & ~clr) | irq_event;
      // write commands; idle codes fall through and do nothing
      if (wr_fall && !cur.cmd_level[HIP_CMD_IDLE_BIT]) begin
         unique case (cur.cmd_level[1:0])
            HIP_CMD_PKT[1:0]: begin
               nxt.pkt_wr = 1'h1;
               nxt.wdata = cur.din_level;
            end
            HIP_CMD_REG[1:0]: begin
               nxt.reg_wr = 1'h1;
               nxt.reg_wd = cur.din_level[7:0];
            end
            HIP_CMD_ADR_LO[1:0]: begin
               nxt.addr[7:0] = cur.din_level[7:0];
            end
            HIP_CMD_ADR_HI[1:0]: begin
               nxt.addr[15:8] = cur.din_level[7:0];
            end
         endcase
      end
      // read start: request data, capture it one cycle later
      if (rd_fall && !cur.cmd_level[HIP_CMD_IDLE_BIT]) begin
         nxt.rd_active = 1'h1;
         nxt.rd_cmd = cur.cmd_level;
         nxt.rd_load = 1'h1;
         nxt.pkt_rd = (cur.cmd_level == HIP_CMD_PKT);
         nxt.reg_rd = (cur.cmd_level == HIP_CMD_REG);
      end
      // status reads are answered here; reg_rd_req still pulses so the core sees every access
      if (cur.rd_load) begin
         unique case (cur.rd_cmd)
            HIP_CMD_PKT: nxt.dout = pkt_rd_data;
            HIP_CMD_REG: begin
               nxt.dout = '0;
               if (cur.addr == HIP_ADR_IRQ_STS) begin
                  nxt.dout[HIP_NUM_IRQ-1:0] = cur.cause;
               end else begin
                  nxt.dout[7:0] = reg_rd_data;
               end
            end
            // address loads read back the address register
            HIP_CMD_ADR_LO: nxt.dout = {{(DATA_W-8){1'b0}}, cur.addr[7:0]};
            HIP_CMD_ADR_HI: nxt.dout = {{(DATA_W-8){1'b0}}, cur.addr[15:8]};
            default: nxt.dout = '0;
         endcase
      end
      // drive ends when the read strobe is seen high again or chip select drops
      if (cur.rd_active && (nxt.rd_level || !cs_ok)) begin
         nxt.rd_active = 1'b0;
      end
   end

   // state register; a strobe pin reset high reads as idle
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cur <= '0;
         cur.rd_sync <= '1;
         cur.wr_sync <= '1;
         cur.cs_sync <= '1;
         cur.cmd_sync <= '1;
         cur.cmd_level <= '1;
         cur.rd_level <= 1'h1;
         cur.wr_level <= 1'h1;
      end else begin
         cur <= nxt;
      end
   end

   // outputs straight from state
   assign host_data_bus_out = cur.dout;
   // drive is held off during the load cycle so the pins never show a stale word
   assign host_data_bus_oe = cur.rd_active && !cur.rd_load;
   assign host_irq = |cur.cause;
   assign pkt_rd_req = cur.pkt_rd;
   assign pkt_wr_req = cur.pkt_wr;
   assign pkt_wr_data = cur.wdata;
   assign reg_rd_req = cur.reg_rd;
   assign reg_wr_req = cur.reg_wr;
   assign reg_addr = cur.addr;
   assign reg_wr_data = cur.reg_wd;

endmodule : hip_port

// ### core/hip_pkg.sv
// hip_pkg: constants for the host parallel port (commands, register addresses, cause bits).
// assumes nothing beyond a SystemVerilog-2012 compiler.
package hip_pkg;
   // command codes on the select lines
   localparam logic [2:0] HIP_CMD_PKT = 3'h0;
   localparam logic [2:0] HIP_CMD_REG = 3'h1;
   localparam logic [2:0] HIP_CMD_ADR_LO = 3'h2;
   localparam logic [2:0] HIP_CMD_ADR_HI = 3'h3;
   localparam int HIP_CMD_IDLE_BIT = 2;
   // internal register addresses
   localparam logic [15:0] HIP_ADR_MGMT_CLR = 16'h1806;
   localparam logic [15:0] HIP_ADR_EE_CLR = 16'h1C04;
   localparam logic [15:0] HIP_ADR_IRQ_STS = 16'h2000;
   localparam logic [15:0] HIP_ADR_RX_CLR = 16'h6403;
   localparam logic [15:0] HIP_ADR_TX_CLR = 16'h6411;
   // cause bit positions
   localparam int HIP_IRQ_MGMT = 0;
   localparam int HIP_IRQ_EE = 1;
   localparam int HIP_IRQ_RX = 2;
   localparam int HIP_IRQ_TX = 3;
   localparam int HIP_NUM_IRQ = 4;
   // synchroniser depth for pins
   localparam int HIP_SYNC_DEPTH = 3;
endpackage : hip_pkg

// ### test/hip_port_properties.sv
// hip_port_chk: concurrent checks on the pins of hip_port, bound to every instance.
// assumes one clock domain, clk_sys with async active-low rst_b.
`timescale 1ns/10ps
module hip_port_chk
   import hip_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic [2:0] host_cmd_select,
   input wire logic host_chip_sel_n,
   input wire logic host_data_bus_oe,
   input wire logic host_irq,
   input wire logic [3:0] irq_event,
   input wire logic pkt_rd_req,
   input wire logic pkt_wr_req,
   input wire logic reg_rd_req,
   input wire logic reg_wr_req
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   property p_wpl; reg_wr_req |=> !reg_wr_req; endproperty
   a_wpl: assert property (p_wpl) else $error("reg write pulse too long");
   property p_rpl; pkt_rd_req |=> !pkt_rd_req; endproperty
   a_rpl: assert property (p_rpl) else $error("pkt read pulse too long");
   property p_oe; $rose(host_data_bus_oe) |-> $past(reg_rd_req) || $past(pkt_rd_req); endproperty
   a_oe: assert property (p_oe) else $error("bus driven without read");
   property p_irq; irq_event != 4'h0 |-> ##[1:2] host_irq; endproperty
   a_irq: assert property (p_irq) else $error("irq not raised");
   // irq may only drop on the edge that issues a clear write, since causes are sticky
   property p_hold; $fell(host_irq) |-> reg_wr_req; endproperty
   a_hold: assert property (p_hold) else $error("irq dropped uncleared");
   property p_cs; reg_wr_req || pkt_wr_req |-> !$past(host_chip_sel_n, 4); endproperty
   a_cs: assert property (p_cs) else $error("write without chip select");
   property p_pkt; pkt_wr_req |-> $past(host_cmd_select) == HIP_CMD_PKT; endproperty
   a_pkt: assert property (p_pkt) else $error("pkt write wrong command");
   property p_reg; reg_wr_req |-> $past(host_cmd_select) == HIP_CMD_REG; endproperty
   a_reg: assert property (p_reg) else $error("reg write wrong command");
   c_rd: cover property ($rose(host_data_bus_oe));
   c_clr: cover property ($fell(host_irq));
   c_pw: cover property (pkt_wr_req);
endmodule : hip_port_chk
bind hip_port hip_port_chk u_chk (.clk_sys, .rst_b, .host_cmd_select, .host_chip_sel_n, .host_data_bus_oe,
   .host_irq, .irq_event, .pkt_rd_req, .pkt_wr_req, .reg_rd_req, .reg_wr_req);

// ### test/hip_host_model.sv
// hip_host_model: behavioural host processor issuing strobed accesses.
// assumes acc is called from one process only, after reset release.
`timescale 1ns/10ps
module hip_host_model (
   input wire logic clk_sys,
   input wire logic [15:0] host_data_bus_out,
   input wire logic host_data_bus_oe,
   output logic [2:0] host_cmd_select,
   output logic [15:0] host_data_bus_in,
   output logic host_chip_sel_n,
   output logic read_strobe_n,
   output logic write_strobe_n
);
   // idle bus until the first access
   initial begin
      host_cmd_select = 3'h7;
      host_data_bus_in = 16'h0000;
      host_chip_sel_n = 1'b1;
      read_strobe_n = 1'b1;
      write_strobe_n = 1'b1;
   end
   // long phases so the three-stage synchronisers always see each level
   task automatic acc(input logic w, input logic [2:0] c, input logic [15:0] d, output logic [15:0] rv);
      @(negedge clk_sys);
      host_chip_sel_n = 1'b0;
      host_cmd_select = c;
      host_data_bus_in = d;
      repeat (4) @(negedge clk_sys);
      if (w) write_strobe_n = 1'b0;
      else read_strobe_n = 1'b0;
      repeat (8) @(negedge clk_sys);
      rv = host_data_bus_oe ? host_data_bus_out : ~host_data_bus_out; // undriven bus reads as the inverse
      write_strobe_n = 1'b1;
      read_strobe_n = 1'b1;
      repeat (6) @(negedge clk_sys);
      host_chip_sel_n = 1'b1;
      host_cmd_select = 3'h7;
      host_data_bus_in = ~d; // released bus shows no stale value
   endtask : acc
endmodule : hip_host_model

// ### test/tb_top.sv
// tb_top: self-checking bench for hip_port driven through the host model.
// assumes the checker is bound from its own file.
`timescale 1ns/10ps
module tb_top;
   import hip_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic [3:0] irq_event = 4'h0;
   logic [2:0] host_cmd_select;
   logic [15:0] host_data_bus_in, host_data_bus_out, pkt_wr_data, reg_addr, q;
   logic host_chip_sel_n, read_strobe_n, write_strobe_n, host_irq;
   logic host_data_bus_oe, pkt_rd_req, pkt_wr_req, reg_rd_req, reg_wr_req;
   logic [7:0] reg_wr_data;
   int n_pr = 0, n_pw = 0, n_rr = 0, n_rw = 0, n_oe = 0, oe_mark = 0;
   int num_errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   logic [15:0] clr_adr [4] = '{HIP_ADR_MGMT_CLR, HIP_ADR_EE_CLR, HIP_ADR_RX_CLR, HIP_ADR_TX_CLR};
   always #5 clk_sys = ~clk_sys;
   hip_port u_dut (.clk_sys, .rst_b, .host_cmd_select, .host_data_bus_in, .host_data_bus_out, .host_data_bus_oe,
      .host_chip_sel_n, .read_strobe_n, .write_strobe_n, .host_irq, .irq_event, .pkt_rd_req,
      .pkt_rd_data(16'hBEEF), .pkt_wr_req, .pkt_wr_data, .reg_rd_req, .reg_wr_req, .reg_addr,
      .reg_wr_data, .reg_rd_data(8'h5A));
   hip_host_model u_host (.clk_sys, .host_data_bus_out, .host_data_bus_oe, .host_cmd_select, .host_data_bus_in,
      .host_chip_sel_n, .read_strobe_n, .write_strobe_n);
   // request pulses and bus drive counted at the falling edge, where registered outputs have settled
   always @(negedge clk_sys) begin
      if (pkt_rd_req) n_pr <= n_pr + 1;
      if (pkt_wr_req) n_pw <= n_pw + 1;
      if (reg_rd_req) n_rr <= n_rr + 1;
      if (reg_wr_req) n_rw <= n_rw + 1;
      if (host_data_bus_oe) n_oe <= n_oe + 1;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // load both address bytes, then one register access
   task automatic reg_acc(input logic [15:0] adr, input logic w, output logic [15:0] rv);
      u_host.acc(1'b1, HIP_CMD_ADR_LO, {8'h00, adr[7:0]}, rv);
      u_host.acc(1'b1, HIP_CMD_ADR_HI, {8'h00, adr[15:8]}, rv);
      u_host.acc(w, HIP_CMD_REG, 16'h00A5, rv);
   endtask : reg_acc
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : complete_run
   // hang guard, well above the roughly 700 cycles of traffic
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         num_errors++;
         complete_run();
      end
   end
   initial begin
      repeat (4) @(negedge clk_sys);
      rst_b = 1'b1;
      repeat (4) @(negedge clk_sys);
      reg_acc(HIP_ADR_IRQ_STS, 1'b0, q);
      chk(q, 16'h0000);
      chk(reg_addr, HIP_ADR_IRQ_STS);
      chk({15'h0000, host_irq}, 16'h0000);
      irq_event = 4'hF;
      @(negedge clk_sys);
      irq_event = 4'h0;
      reg_acc(HIP_ADR_IRQ_STS, 1'b0, q);
      chk(q, 16'h000F);
      chk({15'h0000, host_irq}, 16'h0001);
      $display("status test done");
      for (int i = 0; i < 4; i++) begin
         reg_acc(clr_adr[i], 1'b1, q);
         reg_acc(HIP_ADR_IRQ_STS, 1'b0, q);
         chk(q, 16'h000F & (16'hFFFE << i));
         chk({15'h0000, host_irq}, (i < 3) ? 16'h0001 : 16'h0000);
      end
      chk({15'h0000, host_irq}, 16'h0000);
      chk({8'h00, reg_wr_data}, 16'h00A5);
      reg_acc(HIP_ADR_MGMT_CLR, 1'b0, q);
      chk(q, 16'h005A);
      $display("clear test done");
      u_host.acc(1'b1, HIP_CMD_PKT, 16'hC3A5, q);
      chk(pkt_wr_data, 16'hC3A5);
      u_host.acc(1'b1, 3'h7, 16'h1234, q);
      chk(pkt_wr_data, 16'hC3A5);
      oe_mark = n_oe;
      u_host.acc(1'b0, HIP_CMD_PKT, 16'h0000, q);
      chk(q, 16'hBEEF);
      chk({15'h0000, n_oe != oe_mark}, 16'h0001);
      chk({15'h0000, host_data_bus_oe}, 16'h0000);
      chk(n_rw[15:0], 16'h0004);
      chk(n_rr[15:0], 16'h0007);
      chk(n_pw[15:0], 16'h0001);
      chk(n_pr[15:0], 16'h0001);
      $display("packet test done");
      complete_run();
   end
endmodule : tb_top
